/* File: hdl/port_pin_pkg.sv */
// Purpose: Shared constants for the port 2 pin function select block
// Assumes: Byte-wide register port with an 8-bit address
// Notes:   Mode register layout differs between the two device variants

package port_pin_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OUTPUT_DATA_OFFSET   = 8'h00;
    localparam logic [7:0] DIRECTION_OFFSET     = 8'h01;
    localparam logic [7:0] FUNCTION_MODE_OFFSET = 8'h02;
    localparam logic [7:0] OPEN_DRAIN_OFFSET    = 8'h03;

    // ************************************************************
    // Mode register fields
    // ************************************************************
    localparam int SERIAL_CLOCK_BIT   = 0;
    localparam int SERIAL_IN_BIT      = 1;
    localparam int SERIAL_OUT_BIT     = 2;
    localparam int SERIAL_PMOS_BIT    = 5;
    localparam int EXTERNAL_CLOCK_BIT = 7;

    // Pins that carry the serial roles
    localparam int SERIAL_CLOCK_PIN = 0;
    localparam int SERIAL_IN_PIN    = 1;
    localparam int SERIAL_OUT_PIN   = 2;

    // ************************************************************
    // Reset values and masks
    // ************************************************************
    localparam logic [7:0] MODE_RESET_A      = 8'hD8;
    localparam logic [7:0] MODE_RESET_B      = 8'h58;
    localparam logic [7:0] MODE_WRITABLE_A   = 8'h27;
    localparam logic [7:0] MODE_WRITABLE_B   = 8'hA7;
    localparam logic [7:0] OPEN_DRAIN_RESET  = 8'h00;
    localparam logic [7:0] DIRECTION_RESET   = 8'h00;
    localparam logic [7:0] OUTPUT_DATA_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_READ    = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

endpackage

/* File: hdl/pin_cell.sv */
// Purpose: One port pin: input synchroniser and output driver stage
// Assumes: Pin level arrives asynchronously to ref_clk
// Notes:   Drive choice is registered, so a pin follows its controls
//          one clock later

`timescale 1ns/1ps

module pin_cell (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Pin side
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    // Control side
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic open_drain,
    output logic      pin_level
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_next;
    logic out_next;
    logic oe_next;

    // Level accepted only once the last two stages agree
    assign level_next = (sync2_reg == sync3_reg) ? sync2_reg : pin_level;

    // Open drain never drives high; it releases the pin instead
    assign out_next = drive_val & ~open_drain;
    assign oe_next  = drive_en & (~open_drain | ~drive_val);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_level <= level_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= out_next;
            pin_oe  <= oe_next;
        end
    end

endmodule

/* File: hdl/port_pin_select.sv */
// Purpose: Port 2 pin function select, driver type and general I/O
// Assumes: Serial unit and clock generator sit outside this block
// Notes:   VARIANT_B selects the layout with the external clock bit

`timescale 1ns/1ps

// How it works
// - Variant A mode register resets to D8 so every pin is general I/O.
// - Variant B mode register resets to 58 with all selects cleared.
// - In variant A mode bit 7 always reads 1 and ignores writes.
// - Mode bits 6, 4 and 3 always read 1 and ignore writes.
// - In variant B mode bit 7 hands the shared pin to the external clock.
// - Mode bit 5 turns the serial output PMOS off for open-drain drive.
// - Mode bit 2 makes pin 2 the serial data output whatever its direction.
// - Mode bit 1 makes pin 1 the serial data input whatever its direction.
// - Mode bit 0 makes pin 0 the serial clock pin whatever its direction.
// - Open-drain bit n picks CMOS or NMOS open-drain drive for pin n.
// - Open-drain bits reset to 00 and act only on pins set as outputs.
// - A direction bit of 1 makes a general pin an output, 0 an input.
// - Port reads give stored data for outputs and pin levels for inputs.
// - Direction reads as all ones; direction and data reset to 00.
module port_pin_select
    import port_pin_pkg::*;
#(
    parameter bit VARIANT_B = 1'b0,
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [7:0]           reg_rdata,
    // Port pins
    input  wire logic [PIN_COUNT-1:0] pin_in,
    output logic      [PIN_COUNT-1:0] pin_out,
    output logic      [PIN_COUNT-1:0] pin_oe,
    // Serial unit
    input  wire logic                 serial_out_data,
    input  wire logic                 serial_clk_out,
    input  wire logic                 serial_clk_oe,
    output logic                      serial_in_data,
    output logic                      serial_clk_in,
    // Shared clock pin
    input  wire logic                 shared_pin_in,
    output logic                      ext_clk_select,
    output logic                      ext_clock_out,
    output logic                      count_direction_input
);

    // ************************************************************
    // Variant constants
    // ************************************************************
    localparam logic [7:0] MODE_RESET =
        VARIANT_B ? MODE_RESET_B : MODE_RESET_A;
    localparam logic [7:0] MODE_WRITABLE =
        VARIANT_B ? MODE_WRITABLE_B : MODE_WRITABLE_A;
    localparam logic [7:0] MODE_FIXED = ~MODE_WRITABLE;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]           port_function_mode_reg;
    logic [7:0]           port_function_mode_next;
    logic [7:0]           open_drain_select_reg;
    logic [PIN_COUNT-1:0] port_direction_reg;
    logic [PIN_COUNT-1:0] port_output_data_reg;
    logic [7:0]           reg_rdata_next;

    // Address decode
    logic                 hit_data;
    logic                 hit_direction;
    logic                 hit_mode;
    logic                 hit_open_drain;

    assign hit_data       = (reg_addr == OUTPUT_DATA_OFFSET);
    assign hit_direction  = (reg_addr == DIRECTION_OFFSET);
    assign hit_mode       = (reg_addr == FUNCTION_MODE_OFFSET);
    assign hit_open_drain = (reg_addr == OPEN_DRAIN_OFFSET);

    // Fixed bits are forced so they never hold anything but one
    assign port_function_mode_next =
        (reg_wdata & MODE_WRITABLE) | MODE_FIXED;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_function_mode_reg <= MODE_RESET;
            open_drain_select_reg  <= OPEN_DRAIN_RESET;
            port_direction_reg     <= DIRECTION_RESET[PIN_COUNT-1:0];
            port_output_data_reg   <= OUTPUT_DATA_RESET[PIN_COUNT-1:0];
        end else if (reg_write) begin
            if (hit_mode) begin
                port_function_mode_reg <= port_function_mode_next;
            end
            if (hit_open_drain) begin
                open_drain_select_reg <= reg_wdata;
            end
            if (hit_direction) begin
                port_direction_reg <= reg_wdata[PIN_COUNT-1:0];
            end
            if (hit_data) begin
                port_output_data_reg <= reg_wdata[PIN_COUNT-1:0];
            end
        end
    end

    // ************************************************************
    // Mode field decode
    // ************************************************************
    logic serial_out_pin_select;
    logic serial_in_pin_select;
    logic serial_clock_pin_select;
    logic serial_out_pmos_off;
    logic external_clock_pin_select;

    assign serial_clock_pin_select = port_function_mode_reg[SERIAL_CLOCK_BIT];
    assign serial_in_pin_select    = port_function_mode_reg[SERIAL_IN_BIT];
    assign serial_out_pin_select   = port_function_mode_reg[SERIAL_OUT_BIT];
    assign serial_out_pmos_off     = port_function_mode_reg[SERIAL_PMOS_BIT];
    // Variant A keeps a constant one here, so it must not select anything
    assign external_clock_pin_select =
        VARIANT_B & port_function_mode_reg[EXTERNAL_CLOCK_BIT];

    // ************************************************************
    // Per-pin drive selection
    // ************************************************************
    logic [PIN_COUNT-1:0] drive_en;
    logic [PIN_COUNT-1:0] drive_val;
    logic [PIN_COUNT-1:0] drive_od;
    logic [PIN_COUNT-1:0] pin_level;

    // General I/O default; the serial roles override below
    always_comb begin
        drive_en  = port_direction_reg;
        drive_val = port_output_data_reg;
        drive_od  = open_drain_select_reg[PIN_COUNT-1:0];
        if (serial_out_pin_select) begin
            drive_en[SERIAL_OUT_PIN]  = 1'b1;
            drive_val[SERIAL_OUT_PIN] = serial_out_data;
            drive_od[SERIAL_OUT_PIN]  = serial_out_pmos_off;
        end
        if (serial_in_pin_select) begin
            drive_en[SERIAL_IN_PIN]  = 1'b0;
            drive_val[SERIAL_IN_PIN] = 1'b0;
            drive_od[SERIAL_IN_PIN]  = 1'b0;
        end
        if (serial_clock_pin_select) begin
            drive_en[SERIAL_CLOCK_PIN]  = serial_clk_oe;
            drive_val[SERIAL_CLOCK_PIN] = serial_clk_out;
            drive_od[SERIAL_CLOCK_PIN]  = 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            pin_cell u_pin (
                .ref_clk    (ref_clk),
                .rst_n      (rst_n),
                .pin_in     (pin_in[gi]),
                .pin_out    (pin_out[gi]),
                .pin_oe     (pin_oe[gi]),
                .drive_en   (drive_en[gi]),
                .drive_val  (drive_val[gi]),
                .open_drain (drive_od[gi]),
                .pin_level  (pin_level[gi])
            );
        end
    endgenerate

    // Shared pin is input only here; the port 3 logic drives it otherwise
    logic shared_level;

    pin_cell u_shared_pin (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .pin_in     (shared_pin_in),
        .pin_out    (),
        .pin_oe     (),
        .drive_en   (1'b0),
        .drive_val  (1'b0),
        .open_drain (1'b0),
        .pin_level  (shared_level)
    );

    // ************************************************************
    // Peripheral-facing outputs
    // ************************************************************
    logic serial_in_next;
    logic serial_clk_in_next;
    logic ext_clock_next;
    logic count_dir_next;

    // Deselected roles read idle low so the serial unit sees no edges
    assign serial_in_next =
        serial_in_pin_select & pin_level[SERIAL_IN_PIN];
    assign serial_clk_in_next =
        serial_clock_pin_select & pin_level[SERIAL_CLOCK_PIN];
    // External clock filtered by the synchroniser: slow clocks only
    assign ext_clock_next = external_clock_pin_select & shared_level;
    assign count_dir_next = ~external_clock_pin_select & shared_level;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_in_data        <= 1'b0;
            serial_clk_in         <= 1'b0;
            ext_clk_select        <= 1'b0;
            ext_clock_out         <= 1'b0;
            count_direction_input <= 1'b0;
        end else begin
            serial_in_data        <= serial_in_next;
            serial_clk_in         <= serial_clk_in_next;
            ext_clk_select        <= external_clock_pin_select;
            ext_clock_out         <= ext_clock_next;
            count_direction_input <= count_dir_next;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] port_read_value;

    // Outputs read back stored data, inputs the filtered pin level
    assign port_read_value = 8'(
        (port_direction_reg & port_output_data_reg) |
        (~port_direction_reg & pin_level));

    always_comb begin
        reg_rdata_next = UNMAPPED_READ;
        if (hit_data) begin
            reg_rdata_next = port_read_value;
        end else if (hit_direction) begin
            reg_rdata_next = DIRECTION_READ;
        end else if (hit_mode) begin
            reg_rdata_next = port_function_mode_reg;
        end else if (hit_open_drain) begin
            reg_rdata_next = open_drain_select_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= reg_rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_RESET_A: assert property (
        @(posedge ref_clk)
        $rose(rst_n) && !VARIANT_B |-> port_function_mode_reg == 8'hD8)
        else $error("Variant A mode reset value wrong");

    AST_RESET_B: assert property (
        @(posedge ref_clk)
        $rose(rst_n) && VARIANT_B |-> port_function_mode_reg == 8'h58)
        else $error("Variant B mode reset value wrong");

    AST_BIT7_FIXED_A: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !VARIANT_B |-> port_function_mode_reg[7] && !ext_clk_select)
        else $error("Variant A bit 7 not held at one");

    AST_RESERVED_ONES: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_read && hit_mode |=> (reg_rdata & 8'h58) == 8'h58)
        else $error("Reserved mode bits not read as one");

    AST_EXT_CLOCK: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        external_clock_pin_select ##1 external_clock_pin_select
        |-> ext_clk_select && !count_direction_input)
        else $error("External clock select not routed");

    AST_SO_OPEN_DRAIN: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        serial_out_pin_select && serial_out_pmos_off
        |=> !pin_out[2] && pin_oe[2] == !$past(serial_out_data))
        else $error("Serial output not open drain");

    AST_SO_CMOS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        serial_out_pin_select && !serial_out_pmos_off
        |=> pin_oe[2] && pin_out[2] == $past(serial_out_data))
        else $error("Serial output not driven push-pull");

    AST_SI_INPUT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        serial_in_pin_select |=> !pin_oe[1])
        else $error("Serial input pin still driven");

    AST_SCK_PIN: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        serial_clock_pin_select
        |=> pin_oe[0] == $past(serial_clk_oe))
        else $error("Serial clock enable not followed");

    AST_OPEN_DRAIN_BIT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        port_direction_reg[7] && open_drain_select_reg[7]
        |=> !pin_out[7] && pin_oe[7] == !$past(port_output_data_reg[7]))
        else $error("Open-drain drive wrong on pin 7");

    AST_INPUT_RELEASED: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !port_direction_reg[6] |=> !pin_oe[6])
        else $error("Input pin driven");

    AST_GENERAL_OUT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        port_direction_reg[3] && !open_drain_select_reg[3]
        |=> pin_oe[3] && pin_out[3] == $past(port_output_data_reg[3]))
        else $error("General output not driven");

    AST_PORT_READ: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_read && hit_data && port_direction_reg[4]
        |=> reg_rdata[4] == $past(port_output_data_reg[4]))
        else $error("Output pin read not from data");

    AST_DIRECTION_READ: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_read && hit_direction |=> reg_rdata == 8'hFF)
        else $error("Direction read not all ones");

    AST_MODE_WRITE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_write && hit_mode
        |=> (port_function_mode_reg & MODE_WRITABLE)
            == ($past(reg_wdata) & MODE_WRITABLE))
        else $error("Mode write not stored");

endmodule

/* File: tb/board_model.sv */
// Purpose: Board circuitry on the port pins and on the shared clock pin
// Assumes: Every port pin carries an external pull-up resistor
// Notes:   Two drivers on one pin resolve to unknown, as on a real board

`timescale 1ns/1ps

module board_model (
    // Device side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic       ext_clk_select,
    // Board control
    input  wire logic [7:0] board_val,
    input  wire logic [7:0] board_en,
    input  wire logic       ud_level,
    // Resolved levels
    output logic      [7:0] pin_level,
    output logic            shared_level
);
    logic ext_clk;

    // ************************************************************
    // Slow oscillator, its edges aligned to ref_clk falling edges
    // ************************************************************
    initial begin
        ext_clk = 1'b0;
        forever #400 ext_clk = ~ext_clk;
    end

    // ************************************************************
    // Pin resolution
    // ************************************************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            case ({pin_oe[i], board_en[i]})
                2'h2:    pin_level[i] = pin_out[i];
                2'h1:    pin_level[i] = board_val[i];
                2'h3:    pin_level[i] = 1'bx;
                default: pin_level[i] = 1'b1;
            endcase
        end
    end

    // Oscillator is wired on only once the pin is claimed
    assign shared_level = ext_clk_select ? ext_clk : ud_level;
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the port 2 pin function select block
// Assumes: Variant A and variant B instances share one register port
// Notes:   Variant A drives the board pins; variant B drives only the shared clock pin select

`timescale 1ns/1ps

module testbench
    import port_pin_pkg::*;
;
    logic       ref_clk, rst_n, reg_write, reg_read;
    logic [7:0] reg_addr, reg_wdata, rdata_a, rdata_b;
    logic [7:0] pin_out, pin_oe, pin_level, board_val, board_en;
    logic       serial_out_data, serial_clk_out, serial_clk_oe;
    logic       serial_in_data, serial_clk_in, ud_level, shared_level;
    logic       ext_sel_a, ext_sel_b, ext_clk_b, cdir_a, cdir_b;
    logic [1:0] seen;
    int         n_fail, n_compared;

    // ************************************************************
    // Design and board
    // ************************************************************
    port_pin_select #(.VARIANT_B(1'b0), .PIN_COUNT(8)) port_pin_select_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(rdata_a), .pin_in(pin_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .serial_out_data(serial_out_data),
        .serial_clk_out(serial_clk_out), .serial_clk_oe(serial_clk_oe),
        .serial_in_data(serial_in_data), .serial_clk_in(serial_clk_in),
        .shared_pin_in(shared_level), .ext_clk_select(ext_sel_a),
        .ext_clock_out(), .count_direction_input(cdir_a));

    port_pin_select #(.VARIANT_B(1'b1), .PIN_COUNT(8)) port_pin_select_b_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(rdata_b), .pin_in(pin_level), .pin_out(), .pin_oe(),
        .serial_out_data(serial_out_data), .serial_clk_out(serial_clk_out),
        .serial_clk_oe(serial_clk_oe), .serial_in_data(),
        .serial_clk_in(), .shared_pin_in(shared_level),
        .ext_clk_select(ext_sel_b), .ext_clock_out(ext_clk_b),
        .count_direction_input(cdir_b));

    board_model board_model_inst (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_clk_select(ext_sel_b),
        .board_val(board_val), .board_en(board_en), .ud_level(ud_level),
        .pin_level(pin_level), .shared_level(shared_level));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp_a,
                      input logic [7:0] exp_b, input string name);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        check({name, " variant a"}, exp_a, rdata_a);
        check({name, " variant b"}, exp_b, rdata_b);
    endtask

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        {reg_write, reg_read, reg_addr, reg_wdata} = 18'h0;
        {serial_out_data, serial_clk_out, serial_clk_oe, ud_level} = 4'h0;
        board_en = 8'h0F;
        board_val = 8'h03;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(FUNCTION_MODE_OFFSET, 8'hD8, 8'h58, "mode reset");
        rd(OPEN_DRAIN_OFFSET, 8'h00, 8'h00, "drain reset");
        rd(DIRECTION_OFFSET, 8'hFF, 8'hFF, "direction read");
        rd(OUTPUT_DATA_OFFSET, 8'hF3, 8'hF3, "input levels");
        settle(1);
        check("read data after slot", 8'h00, rdata_a);
        rd(8'h7E, 8'h00, 8'h00, "unmapped read");
        check("enables after reset", 8'h00, pin_oe);
        // Fixed bits survive a write of zeros
        wr(FUNCTION_MODE_OFFSET, 8'h00);
        rd(FUNCTION_MODE_OFFSET, 8'hD8, 8'h58, "fixed bits");
        ud_level <= 1'b1;
        wr(FUNCTION_MODE_OFFSET, 8'h80);
        rd(FUNCTION_MODE_OFFSET, 8'hD8, 8'hD8, "clock bit");
        check("clock select", 8'h02, {6'h0, ext_sel_b, ext_sel_a});
        seen = 2'h0;
        for (int i = 0; i < 200; i++) begin
            settle(1);
            seen |= {ext_clk_b, ~ext_clk_b};
        end
        check("external clock toggles", 8'h03, {6'h0, seen});
        wr(FUNCTION_MODE_OFFSET, 8'h00);
        settle(8);
        check("count direction", 8'h03, {6'h0, cdir_b, cdir_a});
        // Serial roles override the direction bits
        board_en <= 8'h02;
        board_val <= 8'h02;
        {serial_out_data, serial_clk_out, serial_clk_oe} <= 3'h7;
        // Roles claimed first so no pin ever fights the board
        wr(FUNCTION_MODE_OFFSET, 8'h27);
        wr(DIRECTION_OFFSET, 8'h07);
        rd(FUNCTION_MODE_OFFSET, 8'hFF, 8'h7F, "mode readback");
        settle(1);
        check("serial enables", 8'h01, {5'h0, pin_oe[2:0]});
        check("serial clock out", 8'h01, {7'h0, pin_out[0]});
        settle(4);
        check("serial input", 8'h01, {7'h0, serial_in_data});
        check("serial clock in", 8'h01, {7'h0, serial_clk_in});
        serial_out_data <= 1'b0;
        settle(2);
        check("drain out low", 8'h02, {6'h0, pin_oe[2], pin_out[2]});
        serial_out_data <= 1'b1;
        wr(FUNCTION_MODE_OFFSET, 8'h07);
        #1;
        check("drive before update", 8'h00, {7'h0, pin_oe[2]});
        settle(1);
        check("push pull out", 8'h03, {6'h0, pin_oe[2], pin_out[2]});
        // General I/O with CMOS and open-drain drive
        // Board drives low pins only after the device has let go
        wr(DIRECTION_OFFSET, 8'hF0);
        wr(FUNCTION_MODE_OFFSET, 8'h00);
        wr(OUTPUT_DATA_OFFSET, 8'h5A);
        board_en <= 8'h0F;
        board_val <= 8'h03;
        settle(6);
        check("output enables", 8'hF0, pin_oe);
        check("output values", 8'h5A, pin_out);
        rd(OUTPUT_DATA_OFFSET, 8'h53, 8'h53, "mixed port read");
        wr(OPEN_DRAIN_OFFSET, 8'hFF);
        settle(2);
        check("open drain enables", 8'hA0, pin_oe);
        check("open drain values", 8'h00, pin_out);
        rd(OPEN_DRAIN_OFFSET, 8'hFF, 8'hFF, "drain readback");
        rd(DIRECTION_OFFSET, 8'hFF, 8'hFF, "direction after write");
        settle(2);
        final_report();
    end
endmodule
